// *** ftb_pkg.sv ***
/*
  Constants and types shared by the flow-through burst memory port.
  Assumes a single clock domain and a partner that keeps its own rules.
*/
package ftb_pkg;
  localparam int ADDR_W = 16;
  localparam int LANE_W = 9;
  localparam int OFS_W = 2;
  localparam int WORD_W = 2 * LANE_W;
  localparam int LANE_A_LSB = 0;
  localparam int LANE_B_LSB = LANE_W;
  localparam logic [OFS_W-1:0] OFS_RST = 2'h0;
  localparam logic [OFS_W-1:0] CNT_RST = 2'h0;
  localparam logic [OFS_W-1:0] CNT_STEP = 2'h1;
  localparam logic [ADDR_W-OFS_W-1:0] BASE_RST = 14'h0000;
  localparam logic ORDER_LINEAR = 1'b0;

  typedef enum logic [1:0] {
    FTB_IDLE,
    FTB_READ,
    FTB_WRITE
  } ftb_state_t;
endpackage

// *** ftb_burst_ctr.sv ***
/*
  Two-bit burst offset counter, linear or interleaved.
  Assumes the order select is a steady level from the partner.
*/
`timescale 1ns/1ps
`default_nettype none
module ftb_burst_ctr #(
  parameter int OFS_W = ftb_pkg::OFS_W
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [OFS_W-1:0] load_ofs_i,
  input wire logic step_i,
  input wire logic order_i,
  output logic [OFS_W-1:0] ofs_o,
  output logic [OFS_W-1:0] ofs_d_o
);
  logic [OFS_W-1:0] start_q, start_d;
  logic [OFS_W-1:0] cnt_q, cnt_d;

  function automatic logic [OFS_W-1:0] seq(input logic [OFS_W-1:0] s,
                                           input logic [OFS_W-1:0] c,
                                           input logic ord);
    if (ord == ftb_pkg::ORDER_LINEAR) begin
      seq = s + c;
    end else begin
      seq = s ^ c;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    start_d = start_q;
    cnt_d = cnt_q;
    if (load_i) begin
      start_d = load_ofs_i;
      cnt_d = ftb_pkg::CNT_RST;
    end else if (step_i) begin
      cnt_d = cnt_q + ftb_pkg::CNT_STEP;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      start_q <= ftb_pkg::OFS_RST;
      cnt_q <= ftb_pkg::CNT_RST;
    end else begin
      start_q <= start_d;
      cnt_q <= cnt_d;
    end
  end

  // order is read live, never stored: a change mid-burst alters the sequence
  assign ofs_o = seq(start_q, cnt_q, order_i);
  assign ofs_d_o = seq(start_d, cnt_d, order_i);
endmodule // ftb_burst_ctr
`default_nettype wire

// *** ftb_port.sv ***
/*
  Flow-through burst static memory port: array, strobe decode, burst
  sequencing, byte writes and output enable.
  Assumes all inputs synchronous to sys_clk_i except out_enable_n_i.
*/
`timescale 1ns/1ps
`default_nettype none
module ftb_port #(
  parameter int ADDR_W = ftb_pkg::ADDR_W,
  parameter int LANE_W = ftb_pkg::LANE_W
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] word_address_i,
  input wire logic controller_addr_strobe_n_i,
  input wire logic processor_addr_strobe_n_i,
  input wire logic burst_step_n_i,
  input wire logic burst_order_select_i,
  input wire logic global_write_n_i,
  input wire logic write_gate_n_i,
  input wire logic lane_a_write_n_i,
  input wire logic lane_b_write_n_i,
  input wire logic primary_chip_select_n_i,
  input wire logic depth_select_high_i,
  input wire logic depth_select_low_n_i,
  input wire logic out_enable_n_i,
  input wire logic [LANE_W-1:0] lane_a_data_i,
  input wire logic [LANE_W-1:0] lane_b_data_i,
  output logic [LANE_W-1:0] lane_a_data_o,
  output logic [LANE_W-1:0] lane_b_data_o,
  output logic lane_a_data_oe_o,
  output logic lane_b_data_oe_o
);
  localparam int OFS_W = ftb_pkg::OFS_W;
  localparam int WORD_W = 2 * LANE_W;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int LA = ftb_pkg::LANE_A_LSB;
  localparam int LB = ftb_pkg::LANE_B_LSB;

  logic [WORD_W-1:0] mem [DEPTH];
  ftb_pkg::ftb_state_t st_q, st_d;
  logic [ADDR_W-OFS_W-1:0] base_q, base_d;
  logic [OFS_W-1:0] ofs_q, ofs_d;
  logic [ADDR_W-1:0] addr_q, waddr;
  logic load, step, p_acc, c_acc, sel, is_wr, wr_go, we_a, we_b, drive;
  logic [WORD_W-1:0] rd_word;

  //////////////////////////////////////////////////////////////////////////
  // strobe and select decode
  always_comb begin
    sel = !primary_chip_select_n_i && depth_select_high_i &&
          !depth_select_low_n_i;
    p_acc = !processor_addr_strobe_n_i && !primary_chip_select_n_i;
    c_acc = !controller_addr_strobe_n_i && !p_acc;
    is_wr = !global_write_n_i ||
            (!write_gate_n_i && (!lane_a_write_n_i ||
                                 !lane_b_write_n_i));
  end

  //////////////////////////////////////////////////////////////////////////
  // cycle sequencing
  always_comb begin
    st_d = st_q;
    base_d = base_q;
    load = 1'b0;
    step = 1'b0;
    if (p_acc) begin
      // processor strobe ignores the write controls on its own edge
      if (sel) begin
        st_d = ftb_pkg::FTB_READ;
        base_d = word_address_i[ADDR_W-1:OFS_W];
        load = 1'b1;
      end else begin
        st_d = ftb_pkg::FTB_IDLE;
      end
    end else if (c_acc) begin
      if (sel) begin
        st_d = is_wr ? ftb_pkg::FTB_WRITE : ftb_pkg::FTB_READ;
        base_d = word_address_i[ADDR_W-1:OFS_W];
        load = 1'b1;
      end else begin
        st_d = ftb_pkg::FTB_IDLE;
      end
    end else if (st_q != ftb_pkg::FTB_IDLE) begin
      st_d = is_wr ? ftb_pkg::FTB_WRITE : ftb_pkg::FTB_READ;
      step = !burst_step_n_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_q <= ftb_pkg::FTB_IDLE;
      base_q <= ftb_pkg::BASE_RST;
    end else begin
      st_q <= st_d;
      base_q <= base_d;
    end
  end

  ftb_burst_ctr #(
    .OFS_W(OFS_W)
  ) u_ctr (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .load_i(load),
    .load_ofs_i(word_address_i[OFS_W-1:0]),
    .step_i(step),
    .order_i(burst_order_select_i),
    .ofs_o(ofs_q),
    .ofs_d_o(ofs_d)
  );

  assign addr_q = {base_q, ofs_q};
  assign waddr = {base_d, ofs_d};

  //////////////////////////////////////////////////////////////////////////
  // array write: the edge itself commits the word, no external pulse
  always_comb begin
    wr_go = (st_d == ftb_pkg::FTB_WRITE);
    we_a = wr_go && (!global_write_n_i ||
                     (!write_gate_n_i && !lane_a_write_n_i));
    we_b = wr_go && (!global_write_n_i ||
                     (!write_gate_n_i && !lane_b_write_n_i));
  end

  always_ff @(posedge sys_clk_i) begin
    if (we_a) begin
      mem[waddr][LA +: LANE_W] <= lane_a_data_i;
    end
    if (we_b) begin
      mem[waddr][LB +: LANE_W] <= lane_b_data_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // flow-through read and asynchronous enable; these outputs are not
  // registered on purpose, so data shows in the cycle of the address
  assign rd_word = mem[addr_q];
  assign drive = !out_enable_n_i && (st_q == ftb_pkg::FTB_READ);
  assign lane_a_data_o = rd_word[LA +: LANE_W];
  assign lane_b_data_o = rd_word[LB +: LANE_W];
  assign lane_a_data_oe_o = drive;
  assign lane_b_data_oe_o = drive;

  //////////////////////////////////////////////////////////////////////////
  // checks
  logic [OFS_W-1:0] ext_ofs;
  assign ext_ofs = word_address_i[OFS_W-1:0];

  property p_ctl_deselect;
    @(posedge sys_clk_i) disable iff (rst_i)
      (!controller_addr_strobe_n_i && primary_chip_select_n_i)
      |=> (st_q == ftb_pkg::FTB_IDLE);
  endproperty
  a_ctl_deselect: assert property (p_ctl_deselect)
    else $error("controller strobe with primary high did not deselect");

  property p_proc_deselect;
    @(posedge sys_clk_i) disable iff (rst_i)
      (!processor_addr_strobe_n_i && !primary_chip_select_n_i &&
       (!depth_select_high_i || depth_select_low_n_i))
      |=> (st_q == ftb_pkg::FTB_IDLE);
  endproperty
  a_proc_deselect: assert property (p_proc_deselect)
    else $error("processor strobe with depth selects off did not deselect");

  property p_proc_read;
    @(posedge sys_clk_i) disable iff (rst_i)
      (!processor_addr_strobe_n_i && sel)
      |=> (st_q == ftb_pkg::FTB_READ) &&
          (addr_q == $past(word_address_i));
  endproperty
  a_proc_read: assert property (p_proc_read)
    else $error("processor strobe did not begin read at external address");

  property p_ctl_write;
    @(posedge sys_clk_i) disable iff (rst_i)
      (!controller_addr_strobe_n_i && processor_addr_strobe_n_i && sel &&
       !global_write_n_i)
      |=> (st_q == ftb_pkg::FTB_WRITE) &&
          (addr_q == $past(word_address_i));
  endproperty
  a_ctl_write: assert property (p_ctl_write)
    else $error("controller strobe with global write did not begin write");

  property p_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
      (st_q != ftb_pkg::FTB_IDLE && processor_addr_strobe_n_i &&
       controller_addr_strobe_n_i && burst_step_n_i)
      |=> (addr_q == $past(addr_q));
  endproperty
  a_hold: assert property (p_hold)
    else $error("address moved without strobe or step");

  property p_linear;
    @(posedge sys_clk_i) disable iff (rst_i)
      (st_q != ftb_pkg::FTB_IDLE && processor_addr_strobe_n_i &&
       controller_addr_strobe_n_i && !burst_step_n_i &&
       !burst_order_select_i) ##1 !burst_order_select_i
      |-> (addr_q[OFS_W-1:0] == $past(addr_q[OFS_W-1:0]) + 2'h1) &&
          (base_q == $past(base_q));
  endproperty
  a_linear: assert property (p_linear)
    else $error("linear step did not add one modulo four");

  property p_interleave;
    @(posedge sys_clk_i) disable iff (rst_i)
      (!processor_addr_strobe_n_i && sel && burst_order_select_i)
      ##1 (processor_addr_strobe_n_i && controller_addr_strobe_n_i &&
           !burst_step_n_i && burst_order_select_i)
      ##1 burst_order_select_i
      |-> (ofs_q == ($past(ext_ofs, 2) ^ 2'h1));
  endproperty
  a_interleave: assert property (p_interleave)
    else $error("interleaved second address is not start xor one");

  property p_byte_a;
    @(posedge sys_clk_i) disable iff (rst_i)
      (wr_go && global_write_n_i && !write_gate_n_i &&
       !lane_a_write_n_i && lane_b_write_n_i) |-> (we_a && !we_b);
  endproperty
  a_byte_a: assert property (p_byte_a)
    else $error("byte write a touched the wrong lanes");

  property p_global;
    @(posedge sys_clk_i) disable iff (rst_i)
      (!global_write_n_i && (st_q != ftb_pkg::FTB_IDLE) &&
       processor_addr_strobe_n_i && controller_addr_strobe_n_i)
      |-> (we_a && we_b);
  endproperty
  a_global: assert property (p_global)
    else $error("global write did not write both lanes");

  property p_write_back;
    @(posedge sys_clk_i) disable iff (rst_i)
      (!global_write_n_i && !controller_addr_strobe_n_i &&
       processor_addr_strobe_n_i && sel)
      ##1 (processor_addr_strobe_n_i && controller_addr_strobe_n_i &&
           burst_step_n_i && global_write_n_i && write_gate_n_i)
      |-> (rd_word == {$past(lane_b_data_i), $past(lane_a_data_i)});
  endproperty
  a_write_back: assert property (p_write_back)
    else $error("flow-through read did not return the written word");

  property p_float;
    @(posedge sys_clk_i) disable iff (rst_i)
      out_enable_n_i |-> (!lane_a_data_oe_o && !lane_b_data_oe_o);
  endproperty
  a_float: assert property (p_float)
    else $error("lanes driven while output enable high");

  c_read_burst: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    (!processor_addr_strobe_n_i && sel) ##1
    (!burst_step_n_i && processor_addr_strobe_n_i &&
     controller_addr_strobe_n_i) [*3]);
  c_write: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    st_q == ftb_pkg::FTB_WRITE ##1 st_q == ftb_pkg::FTB_WRITE);
  c_deselect: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    st_q == ftb_pkg::FTB_READ ##1 st_q == ftb_pkg::FTB_IDLE);
  c_drive: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    lane_a_data_oe_o ##1 !lane_a_data_oe_o);
endmodule // ftb_port
`default_nettype wire

// *** ftb_ctl_model.sv ***
/*
  Controller-side model of the two data lanes of the burst memory port.
  Assumes the bench says when the controller drives write data.
*/
`timescale 1ns/1ps
`default_nettype none
module ftb_ctl_model (
  input wire logic sys_clk_i,
  input wire logic drive_i,
  input wire logic [17:0] wdata_i,
  input wire logic [8:0] dut_a_i,
  input wire logic [8:0] dut_b_i,
  input wire logic dut_oe_a_i,
  input wire logic dut_oe_b_i,
  output logic [17:0] bus_o,
  output logic clash_o
);
  logic [17:0] last_q;
  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    // released lanes must not keep the old value
    bus_o = ~last_q;
    if (drive_i) bus_o = wdata_i;
    if (dut_oe_a_i) bus_o[8:0] = dut_a_i;
    if (dut_oe_b_i) bus_o[17:9] = dut_b_i;
  end
  assign clash_o = drive_i && (dut_oe_a_i || dut_oe_b_i);
  // remember only driven values, so a released bus shows their inverse
  always_ff @(posedge sys_clk_i) begin
    if (drive_i || dut_oe_a_i || dut_oe_b_i) begin
      last_q <= bus_o;
    end
  end
endmodule // ftb_ctl_model
`default_nettype wire

// *** test_flow_through_burst_sram_port.sv ***
/*
  Self-checking bench for ftb_port with a reference memory.
  Assumes ftb_pkg and ftb_ctl_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_flow_through_burst_sram_port;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic ps_n = 1'b1;
  logic cs_n = 1'b1;
  logic step_n = 1'b1;
  logic order = 1'b0;
  logic [3:0] wr_n = 4'hf; // global, gate, lane a, lane b
  logic [2:0] sel = 3'h2; // primary_n, high, low_n
  logic oe_n = 1'b0;
  logic drive = 1'b0;
  logic [17:0] wdata = 18'h00000;
  logic [17:0] bus;
  logic [8:0] qa, qb;
  logic oea, oeb, clash;
  logic [17:0] ref_mem [int];
  logic [2:0] offs [3] = '{3'h6, 3'h0, 3'h3};
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  //////////////////////////////////////////////////////////////////////////
  ftb_port dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .word_address_i(addr),
    .controller_addr_strobe_n_i(cs_n), .processor_addr_strobe_n_i(ps_n),
    .burst_step_n_i(step_n), .burst_order_select_i(order),
    .global_write_n_i(wr_n[3]), .write_gate_n_i(wr_n[2]),
    .lane_a_write_n_i(wr_n[1]), .lane_b_write_n_i(wr_n[0]),
    .primary_chip_select_n_i(sel[2]), .depth_select_high_i(sel[1]),
    .depth_select_low_n_i(sel[0]), .out_enable_n_i(oe_n),
    .lane_a_data_i(bus[8:0]), .lane_b_data_i(bus[17:9]),
    .lane_a_data_o(qa), .lane_b_data_o(qb),
    .lane_a_data_oe_o(oea), .lane_b_data_oe_o(oeb));
  ftb_ctl_model partner (.sys_clk_i(sys_clk_i), .drive_i(drive),
    .wdata_i(wdata), .dut_a_i(qa), .dut_b_i(qb), .dut_oe_a_i(oea),
    .dut_oe_b_i(oeb), .bus_o(bus), .clash_o(clash));
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [1:0] bofs(input logic [1:0] s, k,
                                      input logic o);
    return o ? (s ^ k) : (s + k);
  endfunction
  function automatic logic [17:0] merge(input logic [17:0] o, n,
                                        input logic [3:0] w);
    logic wa, wb;
    wa = !w[3] || (!w[2] && !w[1]);
    wb = !w[3] || (!w[2] && !w[0]);
    return {wb ? n[17:9] : o[17:9], wa ? n[8:0] : o[8:0]};
  endfunction
  task automatic finish_test();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one bus cycle, driven at the falling edge; oe negated while writing
  task automatic cyc(input logic p, c, s, input logic [3:0] w,
                     input logic [15:0] a, input logic [17:0] d,
                     input logic drv);
    ps_n = p;
    cs_n = c;
    step_n = s;
    wr_n = w;
    addr = a;
    wdata = d;
    drive = drv;
    oe_n = drv;
    @(negedge sys_clk_i);
  endtask
  task automatic chk(input logic e_oe, input logic [17:0] e);
    checked++;
    if ({oeb, oea} !== {2{e_oe}} || (e_oe && {qb, qa} !== e)) begin
      n_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, {e_oe, e},
               {oea, qb, qa});
    end
  endtask
  // deselect first, so the order input never moves under a live burst
  task automatic park();
    sel = 3'h6;
    cyc(1'b1, 1'b0, 1'b1, 4'hf, 16'h0000, 18'h0, 1'b0);
    sel = 3'h2;
  endtask
  task automatic burst_wr(input logic [15:0] a);
    logic [17:0] d;
    logic [15:0] x;
    for (int k = 0; k < 4; k++) begin
      d = 18'($urandom);
      x = {a[15:2], bofs(a[1:0], k[1:0], order)};
      ref_mem[int'(x)] = d;
      cyc(1'b1, k != 0, k == 0, 4'h7, a, d, 1'b1);
    end
  endtask
  task automatic burst_rd(input logic p, input logic [15:0] a);
    logic [15:0] x;
    x = a;
    cyc(p, !p, 1'b1, 4'hf, a, 18'h0, 1'b0);
    chk(1'b1, ref_mem[int'(a)]);
    for (int k = 1; k < 4; k++) begin
      x = {a[15:2], bofs(a[1:0], k[1:0], order)};
      cyc(1'b1, 1'b1, 1'b0, 4'hf, a, 18'h0, 1'b0);
      chk(1'b1, ref_mem[int'(x)]);
    end
    cyc(1'b1, 1'b1, 1'b1, 4'hf, ~a, 18'h0, 1'b0);
    chk(1'b1, ref_mem[int'(x)]);
  endtask
  task automatic byte_wr(input logic [15:0] a, input logic [3:0] w);
    logic [17:0] d;
    d = 18'($urandom);
    ref_mem[int'(a)] = merge(ref_mem[int'(a)], d, w);
    cyc(1'b1, 1'b0, 1'b1, w, a, d, 1'b1);
  endtask
  //////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_i) begin
    cycles++;
    if (clash === 1'b1) begin
      n_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, 1'b0, clash);
    end
    // whole run needs well under 2000 cycles
    if (cycles == 4000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    logic [15:0] a;
    void'($urandom(19));
    repeat (4) @(negedge sys_clk_i);
    rst_i = 1'b0;
    for (int o = 0; o < 2; o++) begin
      park();
      order = o[0];
      for (int s = 0; s < 4; s++) begin
        a = {14'h0abc, s[1:0]};
        burst_wr(a);
        burst_rd(s[0], a);
      end
    end
    $display("test burst_order done");
    a = 16'h1234;
    burst_wr(a);
    for (int w = 0; w < 16; w++) begin
      byte_wr(a, w[3:0]);
      // odd codes suspend right after the write: flow-through write-back
      cyc(w[0], 1'b1, 1'b1, 4'hf, a, 18'h0, 1'b0);
      chk(1'b1, ref_mem[int'(a)]);
    end
    $display("test byte_write done");
    for (int i = 0; i < 3; i++) begin
      cyc(1'b0, 1'b1, 1'b1, 4'hf, a, 18'h0, 1'b0);
      sel = offs[i];
      cyc(1'b0, 1'b1, 1'b1, 4'hf, a + 16'h4, 18'h0, 1'b0);
      if (i == 0)
        chk(1'b1, ref_mem[int'(a)]);
      else
        chk(1'b0, 18'h0);
      cyc(1'b1, 1'b0, 1'b1, 4'h0, a, ~ref_mem[int'(a)], 1'b1);
      chk(1'b0, 18'h0);
      sel = 3'h2;
      cyc(1'b0, 1'b1, 1'b1, 4'hf, a, 18'h0, 1'b0);
      chk(1'b1, ref_mem[int'(a)]);
    end
    $display("test deselect done");
    #2 oe_n = 1'b1;
    #1 chk(1'b0, 18'h0);
    oe_n = 1'b0;
    #1 chk(1'b1, ref_mem[int'(a)]);
    @(negedge sys_clk_i);
    $display("test out_enable done");
    repeat (30) begin
      a = 16'($urandom);
      park();
      order = 1'($urandom);
      burst_wr(a);
      byte_wr({a[15:2], 2'($urandom)}, 4'($urandom));
      burst_rd(1'($urandom), a);
    end
    $display("test random done");
    finish_test();
  end
endmodule // test_flow_through_burst_sram_port
`default_nettype wire
